/* File: logic/rsw_ctrl.sv */
// Reset, sleep and wake-up controller for a small 8-bit core.
// Assumes one 25 MHz clock, a classic Wishbone master and core strobes
// on the same clock; pins arrive asynchronous and are synchronised here.
//
// Overview of operation
// - Reset on power-up, clear pin, watchdog timeout
// - Power-on reset held about 18 ms
// - Pin/watchdog reset length depends on oscillator
// - Reset zeroes program counter, oscillator runs
// - Reset forces all port pins to input
// - Reset clears watchdog counter and prescaler
// - Reset returns control bits to defaults
// - Sleep instruction powers down, clears watchdog
// - Wake waits oscillator-dependent time before resuming
// - Enabled pin, port, conversion events wake
// - Pin/watchdog wake resets, flags record cause
// - Other wakes resume or jump to vector
// - Port 5/7 wake never raises an interrupt
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
module rsw_ctrl #(
  parameter int POR_CYC_P = rsw_pkg::POR_CYC,
  parameter int HXT_CYC_P = rsw_pkg::HXT_CYC,
  parameter int LXT_CYC_P = rsw_pkg::LXT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire rsw_pkg::rsw_osc_e osc_mode_i,
  input wire logic clear_n_i,
  input wire logic ext_interrupt_pin_i,
  input wire logic [7:0] port5_i,
  input wire logic [7:0] port6_i,
  input wire logic [7:0] port7_i,
  input wire logic conv_done_i,
  input wire logic sleep_instruction_i,
  input wire logic global_irq_on_instr_i,
  input wire logic global_irq_off_instr_i,
  output logic core_rst_o,
  output logic core_halt_o,
  output logic osc_run_o,
  output logic port_force_input_o,
  output logic program_counter_load_o,
  output logic [11:0] program_counter_o
);
  import rsw_pkg::*;

  localparam int PIN_W = 26;
  localparam int PIN_CLR = 25;
  localparam int PIN_EXT = 24;

  rsw_state_e st_q;
  rsw_wake_e wake_q;
  rsw_wake_e wake_sel;
  rsw_ctrl_s ctrl_q;
  logic [HOLD_W-1:0] cnt_q;
  logic [HOLD_W-1:0] mode_len;
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  logic [PIN_W-1:0] pin_s3_q;
  logic [PIN_W-1:0] pin_chg;
  logic [15:0] wake_mask_q;
  logic [7:0] wdog_pre_q;
  logic [7:0] wdog_cnt_q;
  logic wdog_tick;
  logic wdog_to;
  logic clr_low;
  logic rst_cause;
  logic wake_any;
  logic wake_irq;
  logic [11:0] wake_vec;
  logic run_irq;
  logic [11:0] run_vec;
  logic to_q;
  logic pd_q;
  logic gie_q;
  logic load_q;
  logic [11:0] pc_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic bus_req;
  logic bus_wr;
  logic kick;
  logic [31:0] rd_mux;

  // Pins are asynchronous: two stages, then a third for change detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
      pin_s3_q <= '1;
    end else begin
      pin_s1_q <= {clear_n_i, ext_interrupt_pin_i, port5_i, port6_i, port7_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Any edge on a pin counts as a change
  assign pin_chg = pin_s2_q ^ pin_s3_q;
  assign clr_low = ~pin_s2_q[PIN_CLR];

  // Watchdog divider tick and timeout
  assign wdog_tick = (wdog_pre_q == WDOG_PRE_TOP);
  assign wdog_to = ctrl_q.wdog_en & wdog_tick &
                   (wdog_cnt_q == WDOG_CNT_TOP);
  assign rst_cause = clr_low | wdog_to;

  // Reset and wake length from the oscillator option
  always_comb begin
    unique case (osc_mode_i)
      OSC_HXT: mode_len = HOLD_W'(HXT_CYC_P - 1);
      OSC_LXT: mode_len = HOLD_W'(LXT_CYC_P - 1);
      default: mode_len = HOLD_W'(RC_CYC - 1);
    endcase
  end

  // Wake source choice; reset causes are handled by the state machine
  always_comb begin
    wake_any = 1'b1;
    wake_sel = WK_EXT;
    if (ctrl_q.ext_pin_wake_en & pin_chg[PIN_EXT]) begin
      wake_sel = WK_EXT;
    end else if (ctrl_q.port6_change_wake_en & |pin_chg[15:8]) begin
      wake_sel = WK_P6;
    end else if (ctrl_q.conv_done_wake_en & conv_done_i) begin
      wake_sel = WK_CONV;
    end else if (|(pin_chg[23:16] & wake_mask_q[7:0]) |
                 |(pin_chg[7:0] & wake_mask_q[15:8])) begin
      wake_sel = WK_P57;
    end else begin
      wake_any = 1'b0;
    end
  end

  // Whether the finished wake jumps, and to where
  always_comb begin
    wake_irq = 1'b0;
    wake_vec = PC_RESET;
    unique case (wake_q)
      WK_EXT: begin
        wake_irq = ctrl_q.ext_pin_irq_en;
        wake_vec = VEC_EXT;
      end
      WK_P6: begin
        wake_irq = ctrl_q.port6_change_irq_en;
        wake_vec = VEC_P6;
      end
      WK_CONV: begin
        wake_irq = ctrl_q.conv_done_irq_en;
        wake_vec = VEC_CONV;
      end
      WK_P57: begin
        wake_irq = 1'b0;
        wake_vec = PC_RESET;
      end
    endcase
  end

  // Awake, events are plain interrupts; wake enables play no part
  always_comb begin
    run_irq = gie_q;
    run_vec = VEC_EXT;
    if (ctrl_q.ext_pin_irq_en & pin_chg[PIN_EXT]) begin
      run_vec = VEC_EXT;
    end else if (ctrl_q.port6_change_irq_en & |pin_chg[15:8]) begin
      run_vec = VEC_P6;
    end else if (ctrl_q.conv_done_irq_en & conv_done_i) begin
      run_vec = VEC_CONV;
    end else begin
      run_irq = 1'b0;
    end
  end

  // Main sequence; a held-low clear pin keeps reloading the hold time
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_HOLD;
      cnt_q <= HOLD_W'(POR_CYC_P - 1);
      wake_q <= WK_EXT;
    end else if ((st_q != ST_HOLD && rst_cause) ||
                 (st_q == ST_HOLD && clr_low)) begin
      st_q <= ST_HOLD;
      cnt_q <= mode_len;
    end else begin
      unique case (st_q)
        ST_HOLD: begin
          if (cnt_q == '0) begin
            st_q <= ST_RUN;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_RUN: begin
          if (sleep_instruction_i) begin
            st_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake_any) begin
            st_q <= ST_WAKE;
            cnt_q <= mode_len;
            wake_q <= wake_sel;
          end
        end
        ST_WAKE: begin
          if (cnt_q == '0) begin
            st_q <= ST_RUN;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
      endcase
    end
  end

  // Program counter loads: zero after reset, vector after wake or event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_q <= 1'b0;
      pc_q <= PC_RESET;
    end else begin
      load_q <= 1'b0;
      if (st_q == ST_HOLD && cnt_q == '0 && !clr_low) begin
        load_q <= 1'b1;
        pc_q <= PC_RESET;
      end else if (st_q == ST_WAKE && cnt_q == '0 && !rst_cause &&
                   gie_q && wake_irq) begin
        load_q <= 1'b1;
        pc_q <= wake_vec;
      end else if (st_q == ST_RUN && !rst_cause && run_irq) begin
        load_q <= 1'b1;
        pc_q <= run_vec;
      end
    end
  end

  // Global interrupt state follows the core's enable/disable strobes
  always_ff @(posedge clk_i) begin
    if (rst_i || st_q == ST_HOLD) begin
      gie_q <= 1'b0;
    end else if (global_irq_on_instr_i) begin
      gie_q <= 1'b1;
    end else if (global_irq_off_instr_i) begin
      gie_q <= 1'b0;
    end
  end

  // Cause flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      to_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      if (st_q != ST_HOLD && wdog_to) begin
        to_q <= 1'b1;
      end else if (bus_wr && wb_adr_i == ADR_STAT && wb_sel_i[0] &&
                   wb_dat_i[STAT_TO]) begin
        to_q <= 1'b0;
      end
      if (st_q == ST_RUN && sleep_instruction_i && !rst_cause) begin
        pd_q <= 1'b1;
      end else if (bus_wr && wb_adr_i == ADR_STAT && wb_sel_i[0] &&
                   wb_dat_i[STAT_PD]) begin
        pd_q <= 1'b0;
      end
    end
  end

  // Watchdog keeps counting in sleep so it can still end a hang
  always_ff @(posedge clk_i) begin
    if (rst_i || st_q == ST_HOLD || kick ||
        (st_q == ST_RUN && sleep_instruction_i)) begin
      wdog_pre_q <= 8'h00;
      wdog_cnt_q <= 8'h00;
    end else if (ctrl_q.wdog_en) begin
      wdog_pre_q <= wdog_pre_q + 8'h01;
      if (wdog_tick) begin
        wdog_cnt_q <= wdog_cnt_q + 8'h01;
      end
    end
  end

  // Bus slave: one wait state, every access answered, unmapped reads 0
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign bus_wr = bus_req & wb_we_i;
  assign kick = bus_wr & (wb_adr_i == ADR_KICK);

  // Control bits return to defaults for every reset
  always_ff @(posedge clk_i) begin
    if (rst_i || st_q == ST_HOLD) begin
      ctrl_q <= rsw_ctrl_s'(CTRL_RST);
      wake_mask_q <= WAKE_RST;
    end else if (bus_wr) begin
      if (wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
        ctrl_q <= rsw_ctrl_s'(wb_dat_i[CTRL_W-1:0]);
      end
      if (wb_adr_i == ADR_WAKE && wb_sel_i[0]) begin
        wake_mask_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_adr_i == ADR_WAKE && wb_sel_i[1]) begin
        wake_mask_q[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // Read selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      ADR_CTRL: rd_mux[CTRL_W-1:0] = ctrl_q;
      ADR_WAKE: rd_mux[15:0] = wake_mask_q;
      ADR_STAT: begin
        rd_mux[STAT_TO] = to_q;
        rd_mux[STAT_PD] = pd_q;
        rd_mux[STAT_GIE] = gie_q;
        rd_mux[STAT_SLEEP] = (st_q == ST_SLEEP);
        rd_mux[STAT_RESET] = (st_q == ST_HOLD);
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Answer registered one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      if (bus_req && !wb_we_i) begin
        dat_q <= rd_mux;
      end
    end
  end

  // Outputs decode registered state only
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign core_rst_o = (st_q == ST_HOLD);
  assign port_force_input_o = (st_q == ST_HOLD);
  assign osc_run_o = (st_q != ST_SLEEP);
  assign core_halt_o = (st_q == ST_SLEEP) || (st_q == ST_WAKE);
  assign program_counter_load_o = load_q;
  assign program_counter_o = pc_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_rc_wake_start;
    $rose(st_q == ST_WAKE) && osc_mode_i == OSC_RC;
  endsequence

  sequence s_rc_wake_body;
    ##33 (st_q == ST_WAKE) ##1 (st_q == ST_RUN);
  endsequence

  chk_clear_pin_reset: assert property (
    st_q != ST_HOLD && clr_low |=> core_rst_o && port_force_input_o)
    else $error("clear pin did not start reset");

  chk_rc_reset_len: assert property (
    st_q != ST_HOLD && clr_low && osc_mode_i == OSC_RC
    |=> cnt_q == HOLD_W'(RC_CYC - 1))
    else $error("reset length wrong for rc mode");

  chk_reset_pc_zero: assert property (
    $fell(core_rst_o) |-> program_counter_load_o && program_counter_o == 12'h000)
    else $error("program counter not zeroed after reset");

  chk_wdog_clear_hold: assert property (
    core_rst_o |=> wdog_cnt_q == 8'h00 && wdog_pre_q == 8'h00)
    else $error("watchdog not cleared by reset");

  chk_sleep_entry_seq: assert property (
    st_q == ST_RUN && sleep_instruction_i && !rst_cause
    |=> st_q == ST_SLEEP && pd_q && wdog_cnt_q == 8'h00 && !osc_run_o)
    else $error("sleep entry incomplete");

  chk_rc_wake_len: assert property (
    s_rc_wake_start |-> s_rc_wake_body)
    else $error("rc wake time not 34 cycles");

  chk_wdog_flag_set: assert property (
    st_q == ST_SLEEP && wdog_to |=> to_q && core_rst_o)
    else $error("watchdog wake did not reset and flag");

  chk_ext_vector_jump: assert property (
    st_q == ST_WAKE && cnt_q == '0 && !rst_cause && gie_q &&
    wake_q == WK_EXT && ctrl_q.ext_pin_irq_en
    |=> program_counter_load_o && program_counter_o == 12'h003)
    else $error("wake did not branch to external vector");

  chk_p57_no_irq: assert property (
    st_q == ST_WAKE && cnt_q == '0 && wake_q == WK_P57
    |=> !program_counter_load_o ##1 !program_counter_load_o || st_q != ST_RUN)
    else $error("port 5/7 wake raised an interrupt");

  chk_run_irq_gate: assert property (
    st_q == ST_RUN && !rst_cause && !gie_q |=> !program_counter_load_o)
    else $error("interrupt taken with global enable off");

endmodule : rsw_ctrl

/* File: logic/rsw_pkg.sv */
// Constants, types and register map for the reset and wake-up controller.
// Assumes a single 25 MHz system clock; all times become cycle counts here.
package rsw_pkg;

  // System clock rate and the documented hold and wake times
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PER_MS = CLK_HZ / 1000;
  localparam int POR_MS = 18;
  localparam int HXT_MS = 2;
  localparam int HXT_EXTRA_CLK = 32;
  localparam int LXT_MS = 500;
  localparam int RC_CLK = 34;

  // Cycle counts derived from the times above
  localparam int POR_CYC = CLK_PER_MS * POR_MS;
  localparam int HXT_CYC = CLK_PER_MS * HXT_MS + HXT_EXTRA_CLK;
  localparam int LXT_CYC = CLK_PER_MS * LXT_MS;
  localparam int RC_CYC = RC_CLK;

  // Hold counter width covers the longest (low crystal) delay
  localparam int HOLD_W = 24;

  // Watchdog: prescaler divides the clock, counter times out at its top
  localparam logic [7:0] WDOG_PRE_TOP = 8'hff;
  localparam logic [7:0] WDOG_CNT_TOP = 8'hff;

  // Register byte offsets on the bus
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_WAKE = 4'h4;
  localparam logic [3:0] ADR_STAT = 4'h8;
  localparam logic [3:0] ADR_KICK = 4'hc;

  // Status register bit positions
  localparam int STAT_TO = 0;
  localparam int STAT_PD = 1;
  localparam int STAT_GIE = 2;
  localparam int STAT_SLEEP = 3;
  localparam int STAT_RESET = 4;

  // Wake vector addresses loaded into the program counter
  localparam int PC_W = 12;
  localparam logic [11:0] PC_RESET = 12'h000;
  localparam logic [11:0] VEC_EXT = 12'h003;
  localparam logic [11:0] VEC_P6 = 12'h006;
  localparam logic [11:0] VEC_CONV = 12'h015;

  // Oscillator option, fixed by the chip configuration
  typedef enum logic [1:0] {
    OSC_RC = 2'h0,
    OSC_HXT = 2'h1,
    OSC_LXT = 2'h2
  } rsw_osc_e;

  typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_SLEEP, ST_WAKE} rsw_state_e;

  typedef enum logic [1:0] {WK_EXT, WK_P6, WK_CONV, WK_P57} rsw_wake_e;

  // Control register fields, bit 6 downward
  typedef struct packed {
    logic conv_done_irq_en;
    logic port6_change_irq_en;
    logic ext_pin_irq_en;
    logic conv_done_wake_en;
    logic port6_change_wake_en;
    logic ext_pin_wake_en;
    logic wdog_en;
  } rsw_ctrl_s;

  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [15:0] WAKE_RST = 16'h0000;

endpackage : rsw_pkg

/* File: testbench/rsw_core_model.sv */
// Core model: issues sleep and global irq strobes, logs pc loads.
// Assumes the controller's clock and its reset and halt outputs.
`timescale 1ns/1ps
module rsw_core_model (
  input wire logic clk_i,
  input wire logic core_rst_i,
  input wire logic core_halt_i,
  input wire logic pc_load_i,
  input wire logic [11:0] pc_i,
  output logic sleep_o,
  output logic irq_on_o,
  output logic irq_off_o
);
  int n_load = 0;
  logic [11:0] last_pc = 12'h000;
  initial begin
    sleep_o = 1'b0;
    irq_on_o = 1'b0;
    irq_off_o = 1'b0;
  end

  // Log every program counter load handed to the core
  always @(posedge clk_i) begin
    if (pc_load_i === 1'b1) begin
      n_load <= n_load + 1;
      last_pc <= pc_i;
    end
  end

  // 0 sleep, 1 irq on, 2 irq off; a core only executes while running
  task automatic strobe(input int which);
    int n;
    n = 0;
    while ((core_rst_i !== 1'b0 || core_halt_i !== 1'b0) && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    @(posedge clk_i);
    sleep_o <= (which == 0);
    irq_on_o <= (which == 1);
    irq_off_o <= (which == 2);
    @(posedge clk_i);
    sleep_o <= 1'b0;
    irq_on_o <= 1'b0;
    irq_off_o <= 1'b0;
  endtask : strobe
endmodule : rsw_core_model

/* File: testbench/rsw_ctrl_bench.sv */
// Self-checking bench for the reset, sleep and wake-up controller.
// Assumes rsw_pkg and the core model; hold counts shortened by parameter.
`timescale 1ns/1ps
module rsw_ctrl_bench;
  import rsw_pkg::*;
  localparam int POR = 100;
  localparam int HXT = 60;
  localparam int LXT = 200;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, we = 1'b0, clr_n = 1'b1, ext = 1'b0, conv = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [7:0] p5 = 8'h00, p6 = 8'h00;
  rsw_osc_e osc = OSC_RC;
  logic ack, crst, halt, oscr, pfi, ld, slp, on, off;
  logic [11:0] pc;
  int n_fail = 0, checked = 0, cycles = 0;

  rsw_ctrl #(.POR_CYC_P(POR), .HXT_CYC_P(HXT), .LXT_CYC_P(LXT)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .osc_mode_i(osc), .clear_n_i(clr_n),
    .ext_interrupt_pin_i(ext), .port5_i(p5), .port6_i(p6),
    .port7_i(8'h00), .conv_done_i(conv), .sleep_instruction_i(slp),
    .global_irq_on_instr_i(on), .global_irq_off_instr_i(off),
    .core_rst_o(crst), .core_halt_o(halt), .osc_run_o(oscr),
    .port_force_input_o(pfi), .program_counter_load_o(ld),
    .program_counter_o(pc));
  rsw_core_model core (.clk_i(clk_i), .core_rst_i(crst),
    .core_halt_i(halt), .pc_load_i(ld), .pc_i(pc), .sleep_o(slp),
    .irq_on_o(on), .irq_off_o(off));

  // 40 ns clock; hang guard well above the longest test
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 80000) begin
      n_fail++;
      $display("[ERR] %0t timeout", $time);
      close_out();
    end
  end

  task automatic chk(input bit ok, input string m);
    checked++;
    if (!ok) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  // Classic single cycle; no latency assumed, only the ack edge counts
  task automatic wb(input bit w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    chk(n < 50, "bus hang");
  endtask : wb

  task automatic count_hi(ref logic s, output int n);
    n = 0;
    while (s === 1'b1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
  endtask : count_hi

  task automatic t_por();
    logic [31:0] q;
    int n;
    repeat (3) @(posedge clk_i);
    chk(crst === 1'b1 && pfi === 1'b1 && oscr === 1'b1, "rst out");
    rst_i <= 1'b0;
    count_hi(crst, n);
    @(posedge clk_i);
    chk(n >= POR - 2 && n <= POR + 3, "power-on hold");
    chk(core.last_pc === PC_RESET && core.n_load == 1, "pc");
    wb(0, ADR_CTRL, 32'h0, q);
    chk(q === 32'h0, "ctrl reset value");
    wb(0, ADR_WAKE, 32'h0, q);
    chk(q === 32'h0, "wake reset value");
    wb(0, ADR_STAT, 32'h0, q);
    chk(q === 32'h0, "status reset value");
    $display("power-on test done");
  endtask : t_por

  // src 0 ext pin, 1 port 6, 2 conversion, 3 port 5 mask
  task automatic t_wake(input int src, input rsw_osc_e m, input int len,
                        input bit gie, input logic [11:0] vec);
    logic [31:0] q;
    int n, l0;
    osc <= m;
    wb(1, ADR_WAKE, (src == 3) ? 32'h1 : 32'h0, q);
    wb(1, ADR_CTRL, (32'h2 << src) | 32'h70, q);
    core.strobe(gie ? 1 : 2);
    core.strobe(0);
    repeat (2) @(posedge clk_i);
    chk(halt === 1'b1 && oscr === 1'b0, "no sleep");
    wb(0, ADR_STAT, 32'h0, q);
    chk(q[STAT_PD] === 1'b1 && q[STAT_SLEEP] === 1'b1, "pd flag");
    l0 = core.n_load;
    @(posedge clk_i);
    case (src)
      0: ext <= ~ext;
      1: p6 <= ~p6;
      2: conv <= 1'b1;
      default: p5 <= ~p5;
    endcase
    @(posedge clk_i);
    conv <= 1'b0;
    count_hi(halt, n);
    @(posedge clk_i);
    chk(n >= len && n <= len + 8, "wake time");
    if (gie && src < 3)
      chk(core.n_load == l0 + 1 && core.last_pc === vec, "vec");
    else
      chk(core.n_load == l0, "stray load");
    $display("wake test %0d done", src);
  endtask : t_wake

  // Awake, a pin change is only an interrupt gated by global enable
  task automatic t_irq(input bit gie);
    logic [31:0] q;
    int l0;
    wb(1, ADR_CTRL, 32'h10, q);
    core.strobe(gie ? 1 : 2);
    l0 = core.n_load;
    @(posedge clk_i);
    ext <= ~ext;
    repeat (8) @(posedge clk_i);
    chk(core.n_load == l0 + gie, "run irq count");
    chk(!gie || core.last_pc === VEC_EXT, "run irq vector");
    $display("run irq test done");
  endtask : t_irq

  task automatic t_clear(input rsw_osc_e m, input int len);
    logic [31:0] q;
    int n, l0;
    osc <= m;
    wb(1, ADR_CTRL, 32'h70, q);
    core.strobe(0);
    @(posedge clk_i);
    ext <= ~ext;
    repeat (60) @(posedge clk_i);
    chk(halt === 1'b1, "woke while disabled");
    clr_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(crst === 1'b1 && pfi === 1'b1, "no reset");
    chk(oscr === 1'b1, "osc stopped in reset");
    wb(1, ADR_CTRL, 32'h7f, q);
    wb(0, ADR_CTRL, 32'h0, q);
    chk(q[6:0] === CTRL_RST, "ctrl in hold");
    l0 = core.n_load;
    clr_n <= 1'b1;
    count_hi(crst, n);
    @(posedge clk_i);
    chk(n >= len && n <= len + 6, "reset length");
    chk(core.n_load == l0 + 1 && core.last_pc === PC_RESET, "pc");
    $display("clear pin test done");
  endtask : t_clear

  // Watchdog keeps counting through sleep and wakes by full reset
  task automatic t_wdog();
    logic [31:0] q;
    int n;
    wb(1, ADR_CTRL, 32'h1, q);
    core.strobe(0);
    n = 0;
    while (crst !== 1'b1 && n < 70000) begin
      @(posedge clk_i);
      n++;
    end
    chk(n > 65000 && n < 66100, "watchdog period");
    count_hi(crst, n);
    wb(0, ADR_STAT, 32'h0, q);
    chk(q[STAT_TO] === 1'b1, "timeout flag");
    wb(0, ADR_CTRL, 32'h0, q);
    chk(q === 32'h0, "ctrl after timeout");
    $display("watchdog test done");
  endtask : t_wdog

  task automatic close_out();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    t_por();
    t_wake(0, OSC_RC, RC_CYC, 1'b1, VEC_EXT);
    t_wake(1, OSC_HXT, HXT, 1'b1, VEC_P6);
    t_wake(2, OSC_LXT, LXT, 1'b1, VEC_CONV);
    t_wake(0, OSC_RC, RC_CYC, 1'b0, VEC_EXT);
    t_wake(3, OSC_RC, RC_CYC, 1'b1, PC_RESET);
    t_irq(1'b1);
    t_irq(1'b0);
    t_clear(OSC_RC, RC_CYC);
    t_wdog();
    close_out();
  end
endmodule : rsw_ctrl_bench
